// ==== design/usbcr_ctrl.v ====
// Decided for this implementation: the AHB-Lite register port and the register addresses.
`timescale 1ns/100ps
`include "usbcr_consts.vh"

// Notes on behaviour
// - Packet disable halts token processing; a received SETUP token sets it.
// - Host enable turns on host mode and D+ and D- pull-downs.
// - Resume signalling is driven exactly while the resume bit is one.
// - Ping-pong reset bit forces all buffer pointers to the even bank.
// - Module enable powers the module and attaches the D+ pull-up, in device view only.
// - Single-ended-zero flag is read-only and follows the bus live.
// - Device view bits fifteen to seven and bit four read zero.

// ============================================================
// Control and status register of a USB full/low-speed module
// with an AHB-Lite slave port and an interrupt output.
module usbcr_ctrl (
	input  wire        clk,
	input  wire        rst,
	input  wire        ce,
	// AHB-Lite slave port.
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output wire        hreadyout,
	output reg  [31:0] hrdata,
	output wire        hresp,
	// Bus line levels and engine status.
	input  wire        line_dp,
	input  wire        line_dm,
	input  wire        low_speed,
	input  wire        setup_token_seen,
	input  wire        token_in_progress,
	input  wire [15:0] pp_toggle,
	// Module controls.
	output wire        usb_module_enable,
	output wire        dp_pullup_en,
	output wire        host_capability_enable,
	output wire        dp_pulldown_en,
	output wire        dm_pulldown_en,
	output wire        resume_drive,
	output wire        packet_processing_disable,
	output wire        frame_marker_enable,
	output wire        bus_reset_control,
	output wire [15:0] pp_odd_bank,
	output wire        irq
);

	// ========================================================
	// Register state.
	reg                      ctl_enable;
	reg                      ctl_pp_rst;
	reg                      ctl_resume;
	reg                      ctl_host_en;
	reg                      ctl_bus_rst;
	reg                      ctl_pkt_dis;
	reg  [`USBCR_IRQ_W-1:0]  irq_stat;
	reg  [`USBCR_IRQ_W-1:0]  irq_mask;
	reg                      se0_prev;
	reg                      wr_pend;
	reg  [`USBCR_ADDR_W-1:0] wr_addr;

	// Bus decode signals.
	wire                     addr_phase;
	wire [`USBCR_ADDR_W-1:0] a_ofs;
	wire                     rd_stat;
	wire                     wr_ctrl;
	wire                     wr_mask;
	wire                     se0_live;
	wire                     j_live;
	wire [`USBCR_IRQ_W-1:0]  irq_events;
	reg  [31:0]              next_rdata;
	reg                      next_enable;
	reg                      next_pp_rst;
	reg                      next_resume;
	reg                      next_host_en;
	reg                      next_bus_rst;
	reg                      next_pkt_dis;
	reg  [`USBCR_IRQ_W-1:0]  next_stat;
	reg  [`USBCR_IRQ_W-1:0]  next_mask;
	reg                      out_module_en;
	reg                      out_frame_en;
	reg                      out_bus_rst;
	reg                      out_irq;

	// ========================================================
	// Live line state.

	assign se0_live = ~line_dp & ~line_dm;
	assign j_live = low_speed ? (~line_dp & line_dm) : (line_dp & ~line_dm);

	// Events that set the sticky interrupt bits.
	assign irq_events[`USBCR_I_SETUP]   = setup_token_seen;
	assign irq_events[`USBCR_I_SE0_ON]  = se0_live & ~se0_prev;
	assign irq_events[`USBCR_I_SE0_OFF] = ~se0_live & se0_prev;

	// ========================================================
	// AHB-Lite decode. The slave stalls only while the clock
	// enable is low, so every transfer is frozen with the state.
	assign hreadyout  = ce;
	assign hresp      = 1'b0;
	assign addr_phase = hsel & hready & htrans[`USBCR_HTRANS_BUSY];
	assign a_ofs      = haddr[`USBCR_ADDR_W-1:0];
	assign rd_stat    = addr_phase & ~hwrite &
		(a_ofs == `USBCR_OFS_IRQ_STAT);
	assign wr_ctrl    = wr_pend & (wr_addr == `USBCR_OFS_CTRL);
	assign wr_mask    = wr_pend & (wr_addr == `USBCR_OFS_IRQ_MASK);

	// Write address is captured in the address phase for use
	// with the data in the following phase.
	always @(posedge clk) begin
		if (rst) begin
			wr_pend <= 1'b0;
			wr_addr <= `USBCR_RST_HADDR;
		end else if (ce) begin
			wr_pend <= addr_phase & hwrite;
			wr_addr <= a_ofs;
		end
	end

	// Read data mux; unmapped offsets read as zero.
	always @* begin
		next_rdata = `USBCR_ZERO32;
		if (a_ofs == `USBCR_OFS_CTRL) begin
			next_rdata[`USBCR_B_ENABLE]  = next_enable;
			next_rdata[`USBCR_B_PP_RST]  = next_pp_rst;
			next_rdata[`USBCR_B_RESUME]  = next_resume;
			next_rdata[`USBCR_B_HOST_EN] = next_host_en;
			next_rdata[`USBCR_B_SE0]     = se0_live;
			if (next_host_en) begin
				next_rdata[`USBCR_B_LIVE_J_FLAG]  = j_live;
				next_rdata[`USBCR_B_PKT_DIS] = token_in_progress;
				next_rdata[`USBCR_B_BUS_RST] = next_bus_rst;
			end else begin
				next_rdata[`USBCR_B_PKT_DIS] = next_pkt_dis;
			end
		end else if (a_ofs == `USBCR_OFS_IRQ_STAT) begin
			next_rdata[`USBCR_IRQ_W-1:0] = irq_stat;
		end else if (a_ofs == `USBCR_OFS_IRQ_MASK) begin
			next_rdata[`USBCR_IRQ_W-1:0] = next_mask;
		end else if (a_ofs == `USBCR_OFS_PP_PTR) begin
			next_rdata[`USBCR_NUM_EP-1:0] = pp_odd_bank;
		end
	end

	// Read data is registered at the end of the address phase.
	always @(posedge clk) begin
		if (rst) begin
			hrdata <= `USBCR_RST_RDATA;
		end else if (ce) begin
			if (addr_phase & ~hwrite) begin
				hrdata <= next_rdata;
			end
		end
	end

	// ========================================================
	// Next register state, from a write in its data phase and
	// from engine events. The read mux and the output flops use
	// these values, so a read issued straight after a write
	// returns the written value rather than a stale one.
	always @* begin
		// Every bit holds unless a write or an event changes it.
		next_enable  = ctl_enable;
		next_pp_rst  = ctl_pp_rst;
		next_resume  = ctl_resume;
		next_host_en = ctl_host_en;
		next_bus_rst = ctl_bus_rst;
		next_pkt_dis = ctl_pkt_dis;
		next_mask    = irq_mask;
		if (wr_ctrl) begin
			next_enable  = hwdata[`USBCR_B_ENABLE];
			next_pp_rst  = hwdata[`USBCR_B_PP_RST];
			next_resume  = hwdata[`USBCR_B_RESUME];
			next_host_en = hwdata[`USBCR_B_HOST_EN];
			if (ctl_host_en) begin
				next_bus_rst = hwdata[`USBCR_B_BUS_RST];
			end else begin
				next_pkt_dis = hwdata[`USBCR_B_PKT_DIS];
			end
		end
		if (setup_token_seen) begin
			next_pkt_dis = 1'b1;
		end
		if (wr_mask) begin
			next_mask = hwdata[`USBCR_IRQ_W-1:0];
		end
		// A status read clears the sticky bits, but an event in
		// the same cycle stays set so that it is not lost.
		if (rd_stat) begin
			next_stat = irq_events;
		end else begin
			next_stat = irq_stat | irq_events;
		end
	end

	// Control register. Bit zero is the module enable in device
	// view and the frame marker enable in host view.
	always @(posedge clk) begin
		if (rst) begin
			ctl_enable  <= `USBCR_RST_BIT;
			ctl_pp_rst  <= `USBCR_RST_BIT;
			ctl_resume  <= `USBCR_RST_BIT;
			ctl_host_en <= `USBCR_RST_BIT;
			ctl_bus_rst <= `USBCR_RST_BIT;
			ctl_pkt_dis <= `USBCR_RST_BIT;
		end else if (ce) begin
			ctl_enable  <= next_enable;
			ctl_pp_rst  <= next_pp_rst;
			ctl_resume  <= next_resume;
			ctl_host_en <= next_host_en;
			ctl_bus_rst <= next_bus_rst;
			ctl_pkt_dis <= next_pkt_dis;
		end
	end

	// ========================================================
	// Interrupts: sticky status cleared by a read, new events
	// win over the clear; mask gates the level output.
	always @(posedge clk) begin
		if (rst) begin
			irq_stat <= `USBCR_RST_IRQ;
			irq_mask <= `USBCR_RST_IRQ;
			se0_prev <= 1'b0;
		end else if (ce) begin
			se0_prev <= se0_live;
			irq_stat <= next_stat;
			irq_mask <= next_mask;
		end
	end

	// ========================================================
	// Ping-pong buffer pointers, one per endpoint.
	genvar ep;
	generate
		for (ep = 0; ep < `USBCR_NUM_EP; ep = ep + 1) begin : g_pp
			usbcr_pp_ptr u_ptr (
				.clk        (clk),
				.rst        (rst),
				.ce         (ce),
				.force_even (ctl_pp_rst),
				.toggle     (pp_toggle[ep]),
				.odd_bank   (pp_odd_bank[ep])
			);
		end
	endgenerate

	// ========================================================
	// Output flops, loaded from the next register state so that
	// they move on the same edge as the register bits and cannot
	// glitch while the bits that they combine change together.
	always @(posedge clk) begin
		if (rst) begin
			out_module_en <= `USBCR_RST_BIT;
			out_frame_en  <= `USBCR_RST_BIT;
			out_bus_rst   <= `USBCR_RST_BIT;
			out_irq       <= `USBCR_RST_BIT;
		end else if (ce) begin
			out_module_en <= next_enable & ~next_host_en;
			out_frame_en  <= next_enable & next_host_en;
			out_bus_rst   <= next_bus_rst & next_host_en;
			out_irq       <= |(next_stat & next_mask);
		end
	end

	// ========================================================
	// Outputs to the transceiver and engine.

	assign usb_module_enable = out_module_en;
	assign dp_pullup_en      = out_module_en;
	assign host_capability_enable = ctl_host_en;
	assign dp_pulldown_en         = ctl_host_en;
	assign dm_pulldown_en         = ctl_host_en;
	assign resume_drive = ctl_resume;
	assign packet_processing_disable = ctl_pkt_dis;
	// Frame marker and bus reset act only in host view.
	assign frame_marker_enable       = out_frame_en;
	assign bus_reset_control         = out_bus_rst;
	// Level interrupt while an unmasked status bit is set.
	assign irq = out_irq;

endmodule // usbcr_ctrl

// ==== design/usbcr_pp_ptr.v ====
`timescale 1ns/100ps
`include "usbcr_consts.vh"

// ============================================================
// One ping-pong buffer pointer: toggles after each finished
// transfer, and is forced to the even bank while reset is held.
module usbcr_pp_ptr (
	input  wire clk,
	input  wire rst,
	input  wire ce,
	input  wire force_even,
	input  wire toggle,
	output reg  odd_bank
);

	// Pointer flop; the bank reset overrides any toggle request.
	always @(posedge clk) begin
		if (rst) begin
			odd_bank <= `USBCR_PP_EVEN;
		end else if (ce) begin
			if (force_even) begin
				odd_bank <= `USBCR_PP_EVEN;
			end else if (toggle) begin
				odd_bank <= ~odd_bank;
			end
		end
	end

endmodule // usbcr_pp_ptr

// ==== shared/usbcr_consts.vh ====
`ifndef USBCR_CONSTS_VH
`define USBCR_CONSTS_VH

// ============================================================
// Register byte offsets on the bus.
`define USBCR_OFS_CTRL      8'h00
`define USBCR_OFS_IRQ_STAT  8'h04
`define USBCR_OFS_IRQ_MASK  8'h08
`define USBCR_OFS_PP_PTR    8'h0C
`define USBCR_ADDR_W        8

// ============================================================
// Control register field positions.
`define USBCR_B_ENABLE      0
`define USBCR_B_PP_RST      1
`define USBCR_B_RESUME      2
`define USBCR_B_HOST_EN     3
`define USBCR_B_BUS_RST     4
`define USBCR_B_PKT_DIS     5
`define USBCR_B_SE0         6
`define USBCR_B_LIVE_J_FLAG      7
`define USBCR_CTRL_W        16

// ============================================================
// Interrupt status and mask field positions.
`define USBCR_IRQ_W         3
`define USBCR_I_SETUP       0
`define USBCR_I_SE0_ON      1
`define USBCR_I_SE0_OFF     2

// ============================================================
// Reset values and sizes.
`define USBCR_RST_BIT       1'b0
`define USBCR_RST_IRQ       3'h0
`define USBCR_RST_HADDR     8'h00
`define USBCR_RST_RDATA     32'h00000000
`define USBCR_NUM_EP        16
`define USBCR_PP_EVEN       1'b0
`define USBCR_ZERO32        32'h00000000
`define USBCR_HTRANS_BUSY   1'b1

`endif

// ==== test/testbench.sv ====
`timescale 1ns/100ps
`include "usbcr_consts.vh"

// ============================================================
// Bench: bus accesses and far-side events with expected values.
module testbench;
	reg         clk;
	reg         rst;
	reg         ce;
	reg         hsel;
	reg  [31:0] haddr;
	reg  [1:0]  htrans;
	reg         hwrite;
	reg  [31:0] hwdata;
	reg  [31:0] rd;
	wire        hreadyout, hresp, irq, line_dp, line_dm, low_speed;
	wire [31:0] hrdata;
	wire [15:0] pp_toggle, pp_odd_bank;
	wire        setup_token_seen, token_in_progress, usb_module_enable;
	wire        dp_pullup_en, host_capability_enable, dp_pulldown_en;
	wire        dm_pulldown_en, resume_drive, packet_processing_disable;
	wire        frame_marker_enable, bus_reset_control;
	integer     bad_count;
	integer     tests_run;

	usbcr_ctrl DUT (.clk, .rst, .ce, .hsel, .haddr, .htrans,
		.hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout,
		.hrdata, .hresp, .line_dp, .line_dm, .low_speed, .setup_token_seen,
		.token_in_progress, .pp_toggle, .usb_module_enable, .dp_pullup_en,
		.host_capability_enable, .dp_pulldown_en, .dm_pulldown_en,
		.resume_drive, .packet_processing_disable, .frame_marker_enable,
		.bus_reset_control, .pp_odd_bank, .irq);
	usbcr_far_end far (.clk, .line_dp, .line_dm, .low_speed,
		.setup_token_seen, .token_in_progress, .pp_toggle);

	// Free-running 100 MHz clock.
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Prints the counts and the verdict, then ends the run.
	task final_report;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Compares one value and counts it.
	task automatic chk(input string nm, input [31:0] e, input [31:0] s);
		tests_run = tests_run + 1;
		if (s !== e) begin
			bad_count = bad_count + 1;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	// Waits a bounded time for hready at a rising edge.
	task automatic wait_rdy;
		integer n;
		n = 0;
		@(posedge clk);
		while (hreadyout !== 1'b1 && n < 50) begin
			@(posedge clk);
			n = n + 1;
		end
		if (n == 50) begin
			bad_count = bad_count + 1;
			final_report;
		end
	endtask
	// One single word transfer: address phase, then data phase.
	task automatic bus(input w, input [7:0] a, input [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= w;
		wait_rdy;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy;
		rd = hrdata;
	endtask
	// Reads a register and compares it.
	task automatic rdc(input string nm, input [7:0] a, input [31:0] e);
		bus(1'b0, a, 32'h00000000);
		chk(nm, e, rd);
	endtask
	// Compares the control outputs one edge later.
	task automatic pins(input [10:0] e);
		@(posedge clk);
		chk("pins", {21'h0, e}, {21'h0, bus_reset_control, hresp,
			host_capability_enable, dp_pulldown_en, dm_pulldown_en,
			usb_module_enable, dp_pullup_en, resume_drive,
			packet_processing_disable, irq, frame_marker_enable});
	endtask

	// Main sequence of tests.
	initial begin
		{bad_count, tests_run} = 0;
		{rst, hsel, haddr, htrans, hwrite, hwdata} = {1'b1, 68'h0};
		ce = 1'b1;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rdc("ctrl", `USBCR_OFS_CTRL, 32'h00000000);
		rdc("status", `USBCR_OFS_IRQ_STAT, 32'h00000000);
		rdc("mask", `USBCR_OFS_IRQ_MASK, 32'h00000000);
		pins(11'h000);
		$display("test reset done");
		far.pulse(1'b0, 16'h8008);
		rdc("ptr", `USBCR_OFS_PP_PTR, 32'h00008008);
		bus(1'b1, `USBCR_OFS_CTRL, 32'hFFFFFFF7);
		rdc("ctrl", `USBCR_OFS_CTRL, 32'h00000027);
		pins(11'h03C);
		rdc("ptr", `USBCR_OFS_PP_PTR, 32'h00000000);
		far.pulse(1'b0, 16'h0008);
		rdc("ptr", `USBCR_OFS_PP_PTR, 32'h00000000);
		bus(1'b1, `USBCR_OFS_CTRL, 32'h00000001);
		far.pulse(1'b0, 16'h0008);
		rdc("ptr", `USBCR_OFS_PP_PTR, 32'h00000008);
		ce <= 1'b0;
		far.pulse(1'b0, 16'h0001);
		chk("ready", 32'h00000000, {31'h0, hreadyout});
		ce <= 1'b1;
		rdc("ptr", `USBCR_OFS_PP_PTR, 32'h00000008);
		$display("test device view done");
		bus(1'b1, `USBCR_OFS_IRQ_MASK, 32'h00000001);
		far.pulse(1'b1, 16'h0000);
		pins(11'h036);
		rdc("status", `USBCR_OFS_IRQ_STAT, 32'h00000001);
		pins(11'h034);
		rdc("ctrl", `USBCR_OFS_CTRL, 32'h00000021);
		bus(1'b1, `USBCR_OFS_CTRL, 32'h00000001);
		rdc("ctrl", `USBCR_OFS_CTRL, 32'h00000001);
		$display("test setup done");
		far.lines(2'h0, 1'b0);
		rdc("ctrl", `USBCR_OFS_CTRL, 32'h00000041);
		far.lines(2'h2, 1'b0);
		rdc("ctrl", `USBCR_OFS_CTRL, 32'h00000001);
		pins(11'h030);
		rdc("status", `USBCR_OFS_IRQ_STAT, 32'h00000006);
		$display("test line state done");
		bus(1'b1, `USBCR_OFS_CTRL, 32'h0000000D);
		pins(11'h1C9);
		rdc("ctrl", `USBCR_OFS_CTRL, 32'h0000008D);
		far.lines(2'h1, 1'b1);
		rdc("ctrl", `USBCR_OFS_CTRL, 32'h0000008D);
		far.lines(2'h2, 1'b1);
		rdc("ctrl", `USBCR_OFS_CTRL, 32'h0000000D);
		bus(1'b1, `USBCR_OFS_CTRL, 32'h0000001D);
		pins(11'h5C9);
		far.busy(1'b1);
		rdc("ctrl", `USBCR_OFS_CTRL, 32'h0000003D);
		far.busy(1'b0);
		bus(1'b1, 8'h10, 32'hFFFFFFFF);
		rdc("unmapped", 8'h10, 32'h00000000);
		bus(1'b1, `USBCR_OFS_CTRL, 32'h00000000);
		pins(11'h000);
		$display("test host view done");
		final_report;
	end
endmodule // testbench

// ==== test/usbcr_ctrl_asserts.sv ====
`timescale 1ns/100ps
`include "usbcr_consts.vh"

// ============================================================
// Checker: control register behaviour seen at the block ports.
module usbcr_chk (
	input wire        clk,
	input wire        rst,
	input wire        ce,
	input wire        hsel,
	input wire [31:0] haddr,
	input wire [1:0]  htrans,
	input wire        hwrite,
	input wire [31:0] hwdata,
	input wire        hready,
	input wire [31:0] hrdata,
	input wire        line_dp,
	input wire        line_dm,
	input wire        low_speed,
	input wire        setup_token_seen,
	input wire        host_capability_enable,
	input wire        dp_pulldown_en,
	input wire        dm_pulldown_en,
	input wire        usb_module_enable,
	input wire        dp_pullup_en,
	input wire        resume_drive,
	input wire        packet_processing_disable,
	input wire [15:0] pp_odd_bank
);
	reg  wr_ph;
	reg  rd_ph;
	wire take = hsel && hready && htrans[1] && ce
		&& haddr[7:0] == `USBCR_OFS_CTRL;
	// Marks the data phase of a control register access.
	always @(posedge clk) begin
		wr_ph <= !rst && take && hwrite;
		rd_ph <= !rst && take && !hwrite;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	AST_SETUP_DIS: assert property (setup_token_seen && ce |=>
		packet_processing_disable) else $error("setup token ignored");
	AST_HOST_PD: assert property (wr_ph && ce |=>
		{host_capability_enable, dp_pulldown_en, dm_pulldown_en}
		== {3{$past(hwdata[3])}}) else $error("host pull-downs wrong");
	AST_RESUME: assert property (wr_ph && ce |=>
		resume_drive == $past(hwdata[2])) else $error("resume wrong");
	AST_PP_EVEN: assert property (wr_ph && ce && hwdata[1] |->
		##[1:2] pp_odd_bank == 16'h0000) else $error("pointers not even");
	AST_ATTACH: assert property (wr_ph && ce |=>
		usb_module_enable == ($past(hwdata[0]) && !$past(hwdata[3]))
		&& dp_pullup_en == usb_module_enable) else $error("attach wrong");
	AST_SE0_LIVE: assert property (rd_ph |-> hrdata[6] ==
		(!$past(line_dp) && !$past(line_dm))) else $error("SE0 flag wrong");
	AST_DEV_ZERO: assert property (rd_ph && !$past(host_capability_enable)
		|-> hrdata[31:7] == 25'h0000000 && !hrdata[4])
		else $error("unimplemented bits not zero");
	AST_J_LIVE: assert property (rd_ph && $past(host_capability_enable)
		|-> hrdata[7] == ($past(low_speed) ? $past(line_dm) && !$past(line_dp)
		: $past(line_dp) && !$past(line_dm))) else $error("J flag wrong");
endmodule // usbcr_chk

bind usbcr_ctrl usbcr_chk u_chk (.clk, .rst, .ce, .hsel, .haddr, .htrans,
	.hwrite, .hwdata, .hready, .hrdata, .line_dp, .line_dm, .low_speed,
	.setup_token_seen, .host_capability_enable, .dp_pulldown_en,
	.dm_pulldown_en, .usb_module_enable, .dp_pullup_en, .resume_drive,
	.packet_processing_disable, .pp_odd_bank);

// ==== test/usbcr_far_end.sv ====
`timescale 1ns/100ps

// ============================================================
// Far side: line levels, SETUP tokens and finished transfers.
module usbcr_far_end (
	input  wire        clk,
	output reg         line_dp,
	output reg         line_dm,
	output reg         low_speed,
	output reg         setup_token_seen,
	output reg         token_in_progress,
	output reg  [15:0] pp_toggle
);
	// Starts in the idle full-speed J state with no activity.
	initial begin
		{line_dp, line_dm, low_speed} = 3'h4;
		{setup_token_seen, token_in_progress} = 2'h0;
		pp_toggle = 16'h0000;
	end
	// Sets the line pair {dp, dm} and the speed.
	task automatic lines(input [1:0] s, input ls);
		@(posedge clk);
		{line_dp, line_dm} <= s;
		low_speed <= ls;
	endtask
	// Sets the token busy level shown in host view.
	task automatic busy(input b);
		@(posedge clk);
		token_in_progress <= b;
	endtask
	// One-cycle pulses for a SETUP token or a finished transfer.
	task automatic pulse(input stp, input [15:0] ep);
		@(posedge clk);
		setup_token_seen <= stp;
		pp_toggle <= ep;
		@(posedge clk);
		setup_token_seen <= 1'b0;
		pp_toggle <= 16'h0000;
	endtask
endmodule // usbcr_far_end
